//--- rtl/usr_sync.sv
// Purpose: Synchronous serial port: receive path, slave mode, sleep wake-up
// Assumes: All pin inputs synchronous to clock; external clock slow vs 50 MHz
// Notes: Master clock period is 2*(baud divisor+1) system cycles
`timescale 1ns/1ps
`default_nettype none
module usr_sync #(
	parameter int FIFO_DEPTH = 2
) (
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire usr_pkg::usr_bus_t bus,
	output var  logic [7:0]    rdata_q,
	input  wire logic          sleep_mode,
	output var  logic          irq_q,
	output var  logic          wake_q,
	input  wire logic          shift_clock_line_i,
	output var  logic          shift_clock_line_o,
	output var  logic          shift_clock_line_oe,
	input  wire logic          serial_data_line_i,
	output var  logic          serial_data_line_o,
	output var  logic          serial_data_line_oe
);
	if (FIFO_DEPTH != 2)
	begin : g_bad_depth
		$error("usr_sync: FIFO_DEPTH must be 2");
	end

	logic [7:0] intctl_q, pflags_q, penable_q, baud_q, txbuf_q;
	logic       port_en_q, rx9_q, single_q, cont_q, addr_en_q, overrun_q;
	logic       clk_src_q, tx9_q, tx_en_q, sync_q, baud_hi_q, tx_ninth_q;
	logic [7:0] brg_cnt_q;
	logic       ck_q, ck_prev_q;
	logic       txbuf_full_q, tsr_busy_q;
	logic [8:0] tsr_q;
	logic [3:0] tx_left_q;
	logic [3:0] rx_cnt_q;
	logic [8:0] rsr_q;
	logic [8:0] fifo_q [FIFO_DEPTH];
	logic [1:0] fifo_cnt_q;

	logic       wr, rd, port_on, master, rx_run, brg_run, brg_tick, clk_run;
	logic       rise_evt, fall_evt, rx_done, push, pop, fifo_full, overrun_set;
	logic       tx_load, rx_flag, tx_flag;
	logic [3:0] rx_last;
	logic [8:0] rx_word;

	assign wr      = bus.we;
	assign rd      = bus.re;
	assign port_on = port_en_q & sync_q;
	assign master  = clk_src_q;
	// Slave ignores single-word enable; continuous wins over single
	assign rx_run  = port_on & (cont_q | (master & single_q));
	assign brg_run = tx_en_q | cont_q | single_q;
	assign brg_tick = brg_run & (brg_cnt_q == 8'h00);
	assign clk_run = port_on & master & (rx_run | (tsr_busy_q & tx_en_q));
	// Same edges in both modes: rise shifts out, fall samples
	assign rise_evt = master ? (brg_tick & ~ck_q & clk_run)
	                         : (port_on & shift_clock_line_i & ~ck_prev_q);
	assign fall_evt = master ? (brg_tick & ck_q)
	                         : (port_on & ~shift_clock_line_i & ck_prev_q);
	assign rx_last   = rx9_q ? usr_pkg::BITS_9_LAST : usr_pkg::BITS_8_LAST;
	assign rx_done   = rx_run & fall_evt & (rx_cnt_q == rx_last);
	assign fifo_full = (fifo_cnt_q == 2'h2);
	assign pop       = rd & (bus.addr == usr_pkg::OFS_RXFIFO) & (fifo_cnt_q != 2'h0);
	assign push        = rx_done & ~overrun_q & ~fifo_full;
	assign overrun_set = rx_done & ~overrun_q & fifo_full;
	assign tx_load  = tx_en_q & ~tsr_busy_q & txbuf_full_q;
	assign rx_flag  = (fifo_cnt_q != 2'h0);
	assign tx_flag  = ~txbuf_full_q;

	always_comb
	begin
		rx_word = rsr_q;
		rx_word[rx_cnt_q] = serial_data_line_i;
	end

	// Baud generator, held in reset with every enable clear
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			brg_cnt_q <= 8'h00;
		else if (!brg_run)
			brg_cnt_q <= 8'h00;
		else if (brg_tick)
			brg_cnt_q <= baud_q;
		else
			brg_cnt_q <= brg_cnt_q - 8'h01;
	end

	// Master clock idles low; a stopped generator drops it at once,
	// else a stuck high level would fake a falling edge on restart
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ck_q      <= 1'b0;
			ck_prev_q <= 1'b0;
		end
		else
		begin
			ck_prev_q <= shift_clock_line_i;
			if (!(port_on & master & brg_run))
				ck_q <= 1'b0;
			else if (brg_tick & ck_q)
				ck_q <= 1'b0;
			else if (brg_tick & clk_run)
				ck_q <= 1'b1;
		end
	end

	// Pin drivers
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_clock_line_oe <= 1'b0;
			serial_data_line_oe <= 1'b0;
		end
		else
		begin
			shift_clock_line_oe <= port_on & master;
			// Receiving releases the data line; transmitter state kept
			serial_data_line_oe <= port_on & tx_en_q & ~rx_run;
		end
	end
	assign shift_clock_line_o = ck_q;

	// Register writes
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			intctl_q   <= usr_pkg::RST_INTCTL;
			pflags_q   <= usr_pkg::RST_PFLAGS;
			penable_q  <= usr_pkg::RST_PENABLE;
			baud_q     <= usr_pkg::RST_BAUD;
			port_en_q  <= usr_pkg::RST_RXSTAT[usr_pkg::RS_PORT_EN];
			rx9_q      <= usr_pkg::RST_RXSTAT[usr_pkg::RS_RX9];
			single_q   <= usr_pkg::RST_RXSTAT[usr_pkg::RS_SINGLE];
			cont_q     <= usr_pkg::RST_RXSTAT[usr_pkg::RS_CONT];
			addr_en_q  <= usr_pkg::RST_RXSTAT[usr_pkg::RS_ADDR_EN];
			clk_src_q  <= usr_pkg::RST_TXSTAT[usr_pkg::TS_CLK_SRC];
			tx9_q      <= usr_pkg::RST_TXSTAT[usr_pkg::TS_TX9];
			tx_en_q    <= usr_pkg::RST_TXSTAT[usr_pkg::TS_TX_EN];
			sync_q     <= usr_pkg::RST_TXSTAT[usr_pkg::TS_SYNC];
			baud_hi_q  <= usr_pkg::RST_TXSTAT[usr_pkg::TS_BAUD_HI];
			tx_ninth_q <= usr_pkg::RST_TXSTAT[usr_pkg::TS_NINTH];
		end
		else
		begin
			if (wr && bus.addr == usr_pkg::OFS_INTCTL)
				intctl_q <= bus.wdata;
			if (wr && bus.addr == usr_pkg::OFS_PFLAGS)
				pflags_q <= bus.wdata;
			if (wr && bus.addr == usr_pkg::OFS_PENABLE)
				penable_q <= {1'b0, bus.wdata[6:0]};
			if (wr && bus.addr == usr_pkg::OFS_BAUD)
				baud_q <= bus.wdata;
			if (wr && bus.addr == usr_pkg::OFS_RXSTAT)
			begin
				port_en_q <= bus.wdata[usr_pkg::RS_PORT_EN];
				rx9_q     <= bus.wdata[usr_pkg::RS_RX9];
				single_q  <= bus.wdata[usr_pkg::RS_SINGLE];
				cont_q    <= bus.wdata[usr_pkg::RS_CONT];
				addr_en_q <= bus.wdata[usr_pkg::RS_ADDR_EN];
			end
			// One word only, then the single enable drops
			if (rx_done & master & ~cont_q)
				single_q <= 1'b0;
			if (wr && bus.addr == usr_pkg::OFS_TXSTAT)
			begin
				clk_src_q  <= bus.wdata[usr_pkg::TS_CLK_SRC];
				tx9_q      <= bus.wdata[usr_pkg::TS_TX9];
				tx_en_q    <= bus.wdata[usr_pkg::TS_TX_EN];
				sync_q     <= bus.wdata[usr_pkg::TS_SYNC];
				baud_hi_q  <= bus.wdata[usr_pkg::TS_BAUD_HI];
				tx_ninth_q <= bus.wdata[usr_pkg::TS_NINTH];
			end
		end
	end

	// Overrun: only a drop of the continuous enable clears it; set wins
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			overrun_q <= 1'b0;
		else if (overrun_set)
			overrun_q <= 1'b1;
		else if (!cont_q)
			overrun_q <= 1'b0;
	end

	// Receive shifter, one bit per falling edge
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_cnt_q <= 4'h0;
			rsr_q    <= 9'h000;
		end
		else if (!rx_run)
			rx_cnt_q <= 4'h0;
		else if (fall_evt)
		begin
			rsr_q[rx_cnt_q] <= serial_data_line_i;
			if (rx_done)
				rx_cnt_q <= 4'h0;
			else
				rx_cnt_q <= rx_cnt_q + 4'h1;
		end
	end

	// Two-entry FIFO, head in entry 0; ninth bit travels with the word
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fifo_cnt_q <= 2'h0;
			for (int i = 0; i < FIFO_DEPTH; i++)
				fifo_q[i] <= 9'h000;
		end
		else if (push & pop)
			fifo_q[0] <= rx_word;
		else if (push)
		begin
			fifo_q[fifo_cnt_q[0]] <= rx_word;
			fifo_cnt_q <= fifo_cnt_q + 2'h1;
		end
		else if (pop)
		begin
			fifo_q[0] <= fifo_q[1];
			fifo_cnt_q <= fifo_cnt_q - 2'h1;
		end
	end

	// Transmit buffer and shifter; write beats a same-cycle transfer
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txbuf_q      <= usr_pkg::RST_TXBUF;
			txbuf_full_q <= 1'b0;
		end
		else if (wr && bus.addr == usr_pkg::OFS_TXBUF)
		begin
			txbuf_q      <= bus.wdata;
			txbuf_full_q <= 1'b1;
		end
		else if (tx_load)
			txbuf_full_q <= 1'b0;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tsr_q              <= 9'h000;
			tx_left_q          <= 4'h0;
			tsr_busy_q         <= 1'b0;
			serial_data_line_o <= 1'b0;
		end
		else if (!tx_en_q)
		begin
			tx_left_q  <= 4'h0;
			tsr_busy_q <= 1'b0;
		end
		else if (tx_load)
		begin
			tsr_q      <= {tx_ninth_q, txbuf_q};
			tx_left_q  <= tx9_q ? usr_pkg::BITS_9 : usr_pkg::BITS_8;
			tsr_busy_q <= 1'b1;
		end
		// Shifting pauses while receiving; state survives for later
		else if (tsr_busy_q & ~rx_run)
		begin
			if (rise_evt && tx_left_q != 4'h0)
			begin
				serial_data_line_o <= tsr_q[0];
				tsr_q     <= {1'b0, tsr_q[8:1]};
				tx_left_q <= tx_left_q - 4'h1;
			end
			else if (fall_evt && tx_left_q == 4'h0)
				tsr_busy_q <= 1'b0;
		end
	end

	// Interrupt request and wake-up from sleep
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_q  <= 1'b0;
			wake_q <= 1'b0;
		end
		else
		begin
			irq_q  <= intctl_q[usr_pkg::IC_GLOBAL] & intctl_q[usr_pkg::IC_PERIPH]
			        & ((rx_flag & penable_q[usr_pkg::PF_RX])
			        | (tx_flag & penable_q[usr_pkg::PF_TX]));
			wake_q <= sleep_mode & ((rx_flag & penable_q[usr_pkg::PF_RX])
			        | (tx_flag & penable_q[usr_pkg::PF_TX]));
		end
	end

	// Read port, data one cycle after the strobe
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= 8'h00;
		else if (rd)
		begin
			unique case (bus.addr)
				usr_pkg::OFS_INTCTL:  rdata_q <= intctl_q;
				usr_pkg::OFS_PFLAGS:  rdata_q <= {1'b0, pflags_q[6], rx_flag, tx_flag,
				                                 pflags_q[3:0]};
				usr_pkg::OFS_RXSTAT:  rdata_q <= {port_en_q, rx9_q, single_q, cont_q,
				                                 addr_en_q, 1'b0, overrun_q,
				                                 fifo_q[0][8]};
				usr_pkg::OFS_TXBUF:   rdata_q <= txbuf_q;
				usr_pkg::OFS_RXFIFO:  rdata_q <= rx_flag ? fifo_q[0][7:0] : 8'h00;
				usr_pkg::OFS_PENABLE: rdata_q <= penable_q;
				usr_pkg::OFS_TXSTAT:  rdata_q <= {clk_src_q, tx9_q, tx_en_q, sync_q, 1'b0,
				                                 baud_hi_q, ~tsr_busy_q, tx_ninth_q};
				usr_pkg::OFS_BAUD:    rdata_q <= baud_q;
				default:              rdata_q <= 8'h00;
			endcase
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_first_fall;
		rx_run && fall_evt && rx_cnt_q == 4'h0;
	endsequence
	sequence s_last_pop;
		pop && fifo_cnt_q == 2'h1 && !push;
	endsequence

	property p_sample_fall;
		s_first_fall |=> rsr_q[0] == $past(serial_data_line_i);
	endproperty
	a_sample_fall: assert property (p_sample_fall) else $error("bit not sampled");

	property p_single_once;
		rx_done && master && single_q && !cont_q && !wr |=> !single_q;
	endproperty
	a_single_once: assert property (p_single_once) else $error("single stays");

	property p_push_flag;
		rx_done && !overrun_q && fifo_cnt_q == 2'h0 |=> rx_flag ##0 fifo_q[0] == $past(rx_word);
	endproperty
	a_push_flag: assert property (p_push_flag) else $error("word not stored");

	property p_flag_clear;
		s_last_pop |=> !rx_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_overrun;
		rx_done && fifo_cnt_q == 2'h2 && !pop |=> overrun_q && fifo_cnt_q == 2'h2;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun missed");

	property p_blocked;
		overrun_q && rx_done && !pop |=> $stable(fifo_cnt_q);
	endproperty
	a_blocked: assert property (p_blocked) else $error("transfer during overrun");

	property p_overrun_clear;
		!cont_q && !rx_done |=> !overrun_q;
	endproperty
	a_overrun_clear: assert property (p_overrun_clear) else $error("overrun kept");

	property p_brg_hold;
		!brg_run [*2] |-> brg_cnt_q == 8'h00 && !brg_tick;
	endproperty
	a_brg_hold: assert property (p_brg_hold) else $error("baud not held");

	property p_half_duplex;
		rx_run |=> !serial_data_line_oe;
	endproperty
	a_half_duplex: assert property (p_half_duplex) else $error("data driven in rx");

	property p_slave_clk;
		!clk_src_q |=> !shift_clock_line_oe;
	endproperty
	a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock");

	property p_wake;
		sleep_mode && rx_flag && penable_q[usr_pkg::PF_RX] |=> wake_q;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");

	property p_clk_idle;
		!brg_run |=> !shift_clock_line_o;
	endproperty
	a_clk_idle: assert property (p_clk_idle) else $error("clock not idle");
endmodule : usr_sync
`default_nettype wire

//--- rtl/usr_pkg.sv
// Purpose: Constants and types for the synchronous serial port receive/slave block
// Assumes: Byte-wide register file on a plain strobe port, one 50 MHz clock
// Notes: Register offsets are byte addresses of an 8-bit space
// Functional notes
// - Either receive enable starts reception in master mode
// - Data sampled on shift clock falling edge
// - Single word once; continuous until cleared, wins
// - Finished word enters FIFO, sets receive flag
// - Receive flag read-only, clears when FIFO empty
// - Receive data is a two-entry FIFO
// - Full FIFO at last bit sets overrun
// - Overrun blocks transfers; cleared by dropping continuous
// - Each data read advances received ninth bit
// - Clock source cleared means external shift clock
// - Slave sleep: second word waits, flag later
// - Transmit flag with enable wakes from sleep
// - Slave mode ignores single-word receive enable
// - Slave receive in sleep wakes on enable
// - Clock source set drives shift clock out
// - Baud generator reset while all enables clear
// - Half duplex: receive and transmit exclude
// - Receive enable pauses transmit, data released
package usr_pkg;
	localparam logic [7:0] OFS_INTCTL  = 8'h0b;
	localparam logic [7:0] OFS_PFLAGS  = 8'h0c;
	localparam logic [7:0] OFS_RXSTAT  = 8'h18;
	localparam logic [7:0] OFS_TXBUF   = 8'h19;
	localparam logic [7:0] OFS_RXFIFO  = 8'h1a;
	localparam logic [7:0] OFS_PENABLE = 8'h8c;
	localparam logic [7:0] OFS_TXSTAT  = 8'h98;
	localparam logic [7:0] OFS_BAUD    = 8'h99;
	// Receive status/control fields
	localparam int RS_PORT_EN = 7;
	localparam int RS_RX9     = 6;
	localparam int RS_SINGLE  = 5;
	localparam int RS_CONT    = 4;
	localparam int RS_ADDR_EN = 3;
	localparam int RS_OVERRUN = 1;
	localparam int RS_NINTH   = 0;
	// Transmit status/control fields
	localparam int TS_CLK_SRC = 7;
	localparam int TS_TX9     = 6;
	localparam int TS_TX_EN   = 5;
	localparam int TS_SYNC    = 4;
	localparam int TS_BAUD_HI = 2;
	localparam int TS_SHIFT_E = 1;
	localparam int TS_NINTH   = 0;
	// Flag/enable fields and global interrupt controls
	localparam int PF_RX = 5;
	localparam int PF_TX = 4;
	localparam int IC_GLOBAL = 7;
	localparam int IC_PERIPH = 6;
	localparam logic [7:0] RST_INTCTL  = 8'h00;
	localparam logic [7:0] RST_PFLAGS  = 8'h00;
	localparam logic [7:0] RST_RXSTAT  = 8'h00;
	localparam logic [7:0] RST_TXBUF   = 8'h00;
	localparam logic [7:0] RST_PENABLE = 8'h00;
	localparam logic [7:0] RST_TXSTAT  = 8'h02;
	localparam logic [7:0] RST_BAUD    = 8'h00;
	localparam logic [3:0] BITS_8_LAST = 4'h7;
	localparam logic [3:0] BITS_9_LAST = 4'h8;
	localparam logic [3:0] BITS_8      = 4'h8;
	localparam logic [3:0] BITS_9      = 4'h9;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} usr_bus_t;
endpackage : usr_pkg

//--- tb/usr_partner.sv
// Purpose: Far-side serial partner feeding words onto the data line
// Assumes: Data changes on shift clock rising edge, LSB first
// Notes: Released data line toggles so a stale bit never passes
`timescale 1ns/1ps
`default_nettype none
module usr_partner (
	input  wire logic clock,
	input  wire logic ck_line,
	input  wire logic dl,
	output var  logic pck,
	output var  logic dat
);
	logic       bits[$];
	logic [7:0] got;

	initial
	begin
		pck = 1'b0;
		dat = 1'b0;
		got = 8'h00;
	end

	// Last eight data bits seen at falling clock edges, LSB first
	always @(negedge ck_line)
		got <= {dl, got[7:1]};

	// One bit per rising edge; toggles once nothing is queued
	always @(posedge ck_line)
		dat <= (bits.size() > 0) ? bits.pop_front() : ~dat;

	task automatic load(input logic [8:0] w, input int n);
		for (int i = 0; i < n; i++)
			bits.push_back(w[i]);
	endtask : load

	// Slave clock stands low between frames
	task automatic pulses(input int n);
		repeat (n)
		begin
			repeat (4) @(posedge clock);
			pck <= 1'b1;
			repeat (4) @(posedge clock);
			pck <= 1'b0;
		end
	endtask : pulses
endmodule : usr_partner
`default_nettype wire

//--- tb/usr_sync_test.sv
// Purpose: Self-checking bench for the synchronous receive/slave block
// Assumes: Baud divisor 3, so one bit takes 8 system cycles
// Notes: Master and slave receive, FIFO, overrun, ninth bit, sleep wake
`timescale 1ns/1ps
`default_nettype none
module usr_sync_test;
	logic              clock;
	logic              rst_n;
	logic              sleep_mode;
	usr_pkg::usr_bus_t bus;
	logic [7:0]        rdata_q;
	logic              irq_q;
	logic              wake_q;
	logic              ck_o;
	logic              ck_oe;
	logic              d_o;
	logic              d_oe;
	logic              pck;
	logic              pdat;
	int                n_fail;
	int                check_count;
	wire               ck_line = ck_oe ? ck_o : pck;
	wire               d_line = d_oe ? d_o : pdat;

	usr_sync #(.FIFO_DEPTH(2)) dut (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata_q(rdata_q),
		.sleep_mode(sleep_mode), .irq_q(irq_q), .wake_q(wake_q), .shift_clock_line_i(ck_line),
		.shift_clock_line_o(ck_o), .shift_clock_line_oe(ck_oe), .serial_data_line_i(d_line),
		.serial_data_line_o(d_o), .serial_data_line_oe(d_oe));
	usr_partner peer (.clock(clock), .ck_line(ck_line), .dl(d_line), .pck(pck), .dat(pdat));

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clock);
		bus.we <= 1'b0;
		@(posedge clock);
	endtask : wr

	// Read data appear in the cycle after the strobe and hold until the next read
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge clock);
		bus.re <= 1'b0;
		@(negedge clock);
		d = rdata_q;
		@(posedge clock);
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask : rc

	task automatic rb(input logic [7:0] a, input int b, input logic e);
		logic [7:0] d;
		rd(a, d);
		chk({7'h00, d[b]}, {7'h00, e});
	endtask : rb

	task automatic wait_bit(input logic [7:0] a, input int b);
		logic [7:0] d;
		d = 8'h00;
		for (int i = 0; i < 200 && d[b] !== 1'b1; i++)
			rd(a, d);
		if (d[b] !== 1'b1)
		begin
			n_fail++;
			$display("BAD t=%0t bit %0d of %h never set", $time, b, a);
		end
	endtask : wait_bit

	task automatic t_reset;
		rc(8'h98, 8'h02);
		rc(8'h18, 8'h00);
		wr(8'h1a, 8'hff);
		rc(8'h1a, 8'h00);
		rc(8'h55, 8'h00);
		$display("done reset");
	endtask : t_reset

	task automatic t_single;
		peer.load(9'h05a, 8);
		wr(8'h99, 8'h03);
		wr(8'h98, 8'h90);
		wr(8'h8c, 8'h20);
		wr(8'h18, 8'ha0);
		@(negedge clock);
		chk({7'h00, ck_oe}, 8'h01);
		@(posedge clock);
		wait_bit(8'h0c, 5);
		rc(8'h18, 8'h80);
		rc(8'h1a, 8'h5a);
		rb(8'h0c, 5, 1'b0);
		chk({7'h00, ck_o}, 8'h00);
		chk({7'h00, d_oe}, 8'h00);
		$display("done single");
	endtask : t_single

	task automatic t_overrun;
		peer.load(9'h011, 8);
		peer.load(9'h022, 8);
		peer.load(9'h033, 8);
		wr(8'h18, 8'h90);
		wait_bit(8'h18, 1);
		rc(8'h18, 8'h92);
		rc(8'h1a, 8'h11);
		rc(8'h1a, 8'h22);
		repeat (80) @(posedge clock);
		rc(8'h1a, 8'h00);
		wr(8'h18, 8'h80);
		rc(8'h18, 8'h80);
		chk({7'h00, ck_o}, 8'h00);
		$display("done overrun");
	endtask : t_overrun

	task automatic t_ninth;
		peer.load(9'h1a5, 9);
		peer.load(9'h0c3, 9);
		wr(8'h18, 8'hc0);
		wr(8'h18, 8'hd0);
		wait_bit(8'h0c, 5);
		// One 9-bit word at divisor 3
		repeat (80) @(posedge clock);
		rc(8'h18, 8'hd1);
		rc(8'h1a, 8'ha5);
		rc(8'h18, 8'hd0);
		rc(8'h1a, 8'hc3);
		wr(8'h18, 8'h80);
		$display("done ninth");
	endtask : t_ninth

	task automatic t_slave;
		wr(8'h98, 8'h10);
		wr(8'h0b, 8'hc0);
		wr(8'h18, 8'ha0);
		peer.load(9'h03c, 8);
		peer.pulses(8);
		chk({7'h00, ck_oe}, 8'h00);
		rb(8'h0c, 5, 1'b0);
		wr(8'h18, 8'h90);
		sleep_mode <= 1'b1;
		peer.load(9'h0c3, 8);
		peer.pulses(8);
		repeat (4) @(posedge clock);
		chk({7'h00, wake_q}, 8'h01);
		chk({7'h00, irq_q}, 8'h01);
		sleep_mode <= 1'b0;
		rc(8'h1a, 8'hc3);
		@(negedge clock);
		chk({7'h00, irq_q}, 8'h00);
		@(posedge clock);
		$display("done slave");
	endtask : t_slave

	// Two words queued, then sleep: flag waits for the second transfer
	task automatic t_slave_tx;
		wr(8'h18, 8'h80);
		wr(8'h98, 8'h30);
		wr(8'h8c, 8'h10);
		wr(8'h19, 8'ha6);
		wr(8'h19, 8'h5b);
		sleep_mode <= 1'b1;
		rb(8'h0c, 4, 1'b0);
		chk({7'h00, wake_q}, 8'h00);
		chk({7'h00, d_oe}, 8'h01);
		peer.pulses(8);
		repeat (4) @(posedge clock);
		chk({7'h00, wake_q}, 8'h01);
		chk(peer.got, 8'ha6);
		sleep_mode <= 1'b0;
		rb(8'h0c, 4, 1'b1);
		wr(8'h98, 8'h10);
		$display("done slave tx");
	endtask : t_slave_tx

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	initial
	begin
		n_fail = 0;
		check_count = 0;
		rst_n = 1'b0;
		sleep_mode = 1'b0;
		bus = '0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_reset;
		t_single;
		t_overrun;
		t_ninth;
		t_slave;
		t_slave_tx;
		complete_run;
	end

	// Whole run needs well under 5000 cycles
	initial
	begin
		repeat (20000) @(posedge clock);
		n_fail++;
		complete_run;
	end
endmodule : usr_sync_test
`default_nettype wire
